//--- rtl/lcd_drive_pkg.sv
// Register map, field layout and reset values of the segment LCD driver
package lcd_drive_pkg;
  // Byte addresses on the 8-bit register bus address
  localparam logic [7:0] MAIN_CTRL_ADDR  = 8'h00;
  localparam logic [7:0] CPUMP_CTRL_ADDR = 8'h04;
  localparam logic [7:0] PHASE_CTRL_ADDR = 8'h08;
  localparam logic [7:0] SEG_EN_BASE     = 8'h10;
  localparam logic [7:0] PIXEL_BASE      = 8'h80;
  localparam int SEG_EN_REGS = 4;
  localparam int PIXEL_REGS  = 32;
  // Main control fields
  localparam int MC_ENABLE_BIT = 15;
  localparam int MC_WR_ERR_BIT = 5;
  localparam int MC_CLKSRC_LSB = 3;
  localparam int MC_MUX_LSB    = 0;
  // Charge pump control fields
  localparam int CP_PUMP_BIT   = 15;
  localparam int CP_LEVEL_LSB  = 3;
  localparam int CP_THIRD_BIT  = 2;
  localparam int CP_CLK_LSB    = 0;
  localparam logic [2:0] CP_LEVEL_RESET = 3'h7;
  localparam logic       CP_THIRD_RESET = 1'b1;
  // Phase control fields
  localparam int PH_WAVE_BIT      = 7;
  localparam int PH_BIAS_MODE_BIT = 6;
  localparam int PH_ACTIVE_BIT    = 5;
  localparam int PH_WR_ALLOW_BIT  = 4;
  localparam int PH_PRE_LSB    = 0;
  // Segment pins shared with commons four to seven
  localparam int SHARED_SEG_BASE = 59;
  localparam logic [2:0] MUX_STATIC = 3'h0;
  localparam logic [2:0] MUX_FIVE   = 3'h4;
  // Mask of implemented segment enable bits (segment 63 absent)
  localparam logic [63:0] SEG_IMPL_MASK = 64'h7FFF_FFFF_FFFF_FFFF;
  // Bias selection codes
  localparam logic [1:0] BIAS_STATIC = 2'h0;
  localparam logic [1:0] BIAS_HALF   = 2'h1;
  localparam logic [1:0] BIAS_THIRD  = 2'h2;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Scan sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_RUN   = 3'b010,
    ST_DRAIN = 3'b100
  } scan_state_t;
endpackage

//--- rtl/segment_lcd_drive_control.sv
// Segment LCD driver control: AXI4-Lite registers and commons/segment scan
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
module segment_lcd_drive_control
(
  input  wire logic        aclk,            // System clock, 20 MHz
  input  wire logic        aresetn,         // Synchronous reset, low
  input  wire logic [7:0]  s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [7:0]  s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  input  wire logic        lcd_clk_tick,    // One pulse per LCD clock
  output logic [1:0]       lcd_clk_source,  // Selected LCD clock source
  output logic [7:0]       com_select,      // One-hot active common
  output logic [7:0]       com_pin_enable,  // Common pins in use
  output logic [63:0]      segment_line,    // Pixel-on level per segment
  output logic [63:0]      seg_pin_enable,  // Pin owned by segment driver
  output logic             drive_polarity,  // Waveform phase
  output logic [1:0]       bias_select,     // Static, half or third bias
  output logic             charge_pump_on,  // Internal top level
  output logic [2:0]       regulator_level, // Peak level code
  output logic             regulator_third, // Third-bias regulator mode
  output logic [1:0]       regulator_clock, // Regulator clock select
  output logic             regulator_on     // Regulator running
);
  import lcd_drive_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic              aw_held;
    logic [7:0]        aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              aw_rdy;
    logic              w_rdy;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              ar_rdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              enable;
    logic              wr_err;
    logic [1:0]        clk_src;
    logic [2:0]        mux;
    logic              pump;
    logic [2:0]        level;
    logic              third;
    logic [1:0]        reg_clk;
    logic              reg_on;
    logic              wave_b;
    logic              bias_mode;
    logic [3:0]        pre;
    logic [63:0]       seg_en;
    logic [31:0][15:0] pix;
    scan_state_t       state;
    logic [3:0]        pre_cnt;
    logic [2:0]        com;
    logic              half;
    logic              frame_pol;
    logic [7:0]        com_sel;
    logic [7:0]        com_pins;
    logic [63:0]       seg_out;
    logic [63:0]       seg_pins;
    logic              pol;
    logic [1:0]        bias;
  } state_t;

  state_t s_reg;
  state_t s_next;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Byte-lane merge of a 16-bit register; upper lanes carry nothing
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] r;
    r = old;
    if (strb[0])
      r[7:0] = data[7:0];
    if (strb[1])
      r[15:8] = data[15:8];
    return r;
  endfunction

  // Write allowed while idle, or in the final phase of the last common
  function automatic logic wr_allow_of(input state_t s);
    return (s.state == ST_IDLE) ||
           (s.com == last_com(s.mux) && (s.wave_b || s.half));
  endfunction

  // Index of the last scanned common: static and 1/2..1/8 mux
  function automatic logic [2:0] last_com(input logic [2:0] mux);
    return mux;
  endfunction

  // Readback of the register at a byte address
  function automatic logic [32:0] read_reg(input state_t s,
                                           input logic [7:0] a);
    logic [15:0] v;
    logic        hit;
    v = 16'h0000;
    hit = 1'b1;
    if (a == MAIN_CTRL_ADDR)
    begin
      v[MC_ENABLE_BIT] = s.enable;
      v[MC_WR_ERR_BIT] = s.wr_err;
      v[MC_CLKSRC_LSB +: 2] = s.clk_src;
      v[MC_MUX_LSB +: 3] = s.mux;
    end
    else if (a == CPUMP_CTRL_ADDR)
    begin
      v[CP_PUMP_BIT] = s.pump;
      v[CP_LEVEL_LSB +: 3] = s.level;
      v[CP_THIRD_BIT] = s.third;
      v[CP_CLK_LSB +: 2] = s.reg_clk;
    end
    else if (a == PHASE_CTRL_ADDR)
    begin
      v[PH_WAVE_BIT] = s.wave_b;
      v[PH_BIAS_MODE_BIT] = s.bias_mode;
      v[PH_ACTIVE_BIT] = (s.state != ST_IDLE);
      v[PH_WR_ALLOW_BIT] = wr_allow_of(s);
      v[PH_PRE_LSB +: 4] = s.pre;
    end
    else if (a >= SEG_EN_BASE && a < SEG_EN_BASE + 8'h10)
      v = s.seg_en[16 * a[3:2] +: 16];
    else if (a >= PIXEL_BASE)
      v = s.pix[a[6:2]];
    else
      hit = 1'b0;
    if (a[1:0] != 2'h0)
      hit = 1'b0;
    return {hit, 16'h0000, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    logic [7:0]  a;
    logic [15:0] v;
    logic [32:0] rd;
    logic        step;
    logic        adv;
    logic        frame_end;
    a = 8'h00;
    v = 16'h0000;
    rd = 33'h0_0000_0000;
    step = 1'b0;
    adv = 1'b0;
    frame_end = 1'b0;
    s_next = s_reg;

    // Address and data are held until both have arrived
    if (s_axi_awvalid && s_reg.aw_rdy)
    begin
      s_next.aw_held = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.w_rdy)
    begin
      s_next.w_held = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;

    // Register write once both halves are held
    if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid)
    begin
      a = s_reg.aw_addr;
      rd = read_reg(s_reg, a);
      v = merge16(rd[15:0], s_reg.w_data, s_reg.w_strb);
      s_next.aw_held = 1'b0;
      s_next.w_held = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      if (rd[32] && a == MAIN_CTRL_ADDR)
      begin
        s_next.enable = v[MC_ENABLE_BIT];
        // Error flag is clear-only from software
        if (!v[MC_WR_ERR_BIT])
          s_next.wr_err = 1'b0;
        s_next.clk_src = v[MC_CLKSRC_LSB +: 2];
        s_next.mux = v[MC_MUX_LSB +: 3];
      end
      else if (rd[32] && a == CPUMP_CTRL_ADDR)
      begin
        s_next.pump = v[CP_PUMP_BIT];
        s_next.level = v[CP_LEVEL_LSB +: 3];
        s_next.third = v[CP_THIRD_BIT];
        s_next.reg_clk = v[CP_CLK_LSB +: 2];
      end
      else if (rd[32] && a == PHASE_CTRL_ADDR)
      begin
        s_next.wave_b = v[PH_WAVE_BIT];
        s_next.bias_mode = v[PH_BIAS_MODE_BIT];
        s_next.pre = v[PH_PRE_LSB +: 4];
      end
      else if (rd[32] && a >= SEG_EN_BASE && a < PIXEL_BASE)
        s_next.seg_en[16 * a[3:2] +: 16] = v;
      else if (rd[32] && a >= PIXEL_BASE)
      begin
        // Refused writes leave the pixel untouched
        if (wr_allow_of(s_reg))
          s_next.pix[a[6:2]] = v;
        else
          s_next.wr_err = 1'b1;
      end
    end
    s_next.seg_en = s_next.seg_en & SEG_IMPL_MASK;

    // Read channel: one read at a time, answered the next cycle
    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_reg.ar_rdy)
    begin
      rd = read_reg(s_reg, s_axi_araddr);
      s_next.rvalid = 1'b1;
      s_next.rdata = rd[31:0];
      s_next.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
    end

    // Prescaler: one scan step every pre+1 LCD clocks
    if (s_reg.state != ST_IDLE && lcd_clk_tick)
    begin
      if (s_reg.pre_cnt == s_reg.pre)
      begin
        s_next.pre_cnt = 4'h0;
        step = 1'b1;
      end
      else
        s_next.pre_cnt = s_reg.pre_cnt + 4'h1;
    end

    // Type-A: two phases per common; type-B: one per common
    if (step)
    begin
      if (!s_reg.wave_b && !s_reg.half)
        s_next.half = 1'b1;
      else
      begin
        s_next.half = 1'b0;
        adv = 1'b1;
      end
    end
    if (adv)
    begin
      if (s_reg.com >= last_com(s_reg.mux))
      begin
        s_next.com = 3'h0;
        frame_end = 1'b1;
        s_next.frame_pol = ~s_reg.frame_pol;
      end
      else
        s_next.com = s_reg.com + 3'h1;
    end

    // Sequencer: a disable finishes the current frame first
    unique case (s_reg.state)
      ST_IDLE:
        if (s_reg.enable)
        begin
          s_next.state = ST_RUN;
          s_next.pre_cnt = 4'h0;
          s_next.com = 3'h0;
          s_next.half = 1'b0;
          s_next.frame_pol = 1'b0;
        end
      ST_RUN:
        if (!s_reg.enable)
          s_next.state = ST_DRAIN;
      ST_DRAIN:
        if (s_reg.enable)
          s_next.state = ST_RUN;
        else if (frame_end)
          s_next.state = ST_IDLE;
      default:
        s_next.state = ST_IDLE;
    endcase

    // Bus readies follow the held flags
    s_next.aw_rdy = !s_next.aw_held && !s_next.bvalid;
    s_next.w_rdy = !s_next.w_held && !s_next.bvalid;
    s_next.ar_rdy = !s_next.rvalid;

    // Drive outputs from the next scan position
    s_next.com_sel = 8'h00;
    s_next.seg_out = 64'h0;
    if (s_next.state != ST_IDLE)
    begin
      s_next.com_sel[s_next.com] = 1'b1;
      s_next.seg_out = {s_next.pix[{s_next.com, 2'h3}],
                        s_next.pix[{s_next.com, 2'h2}],
                        s_next.pix[{s_next.com, 2'h1}],
                        s_next.pix[{s_next.com, 2'h0}]};
    end
    for (int k = 0; k < 8; k++)
      s_next.com_pins[k] = (3'(k) <= s_next.mux);
    s_next.seg_pins = s_next.seg_en;
    // Commons four..seven take their shared segment pins
    if (s_next.mux >= MUX_FIVE)
      s_next.seg_pins[SHARED_SEG_BASE +: 4] = 4'h0;
    s_next.seg_out = s_next.seg_out & s_next.seg_pins;
    s_next.pol = s_next.wave_b ? s_next.frame_pol : s_next.half;
    if (s_next.mux == MUX_STATIC)
      s_next.bias = BIAS_STATIC;
    else if (s_next.mux <= 3'h2 && s_next.bias_mode)
      s_next.bias = BIAS_HALF;
    else
      s_next.bias = BIAS_THIRD;
    // Clock code zero floats the regulator; kept in a flop for the pin
    s_next.reg_on = |s_next.reg_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers: everything zero except regulator level and mode, the idle state and the common zero pin enable
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
      s_reg.state <= ST_IDLE;
      s_reg.level <= CP_LEVEL_RESET;
      s_reg.third <= CP_THIRD_RESET;
      s_reg.com_pins <= 8'h01;
    end
    else
      s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state
  assign s_axi_awready   = s_reg.aw_rdy;
  assign s_axi_wready    = s_reg.w_rdy;
  assign s_axi_bvalid    = s_reg.bvalid;
  assign s_axi_bresp     = s_reg.bresp;
  assign s_axi_arready   = s_reg.ar_rdy;
  assign s_axi_rvalid    = s_reg.rvalid;
  assign s_axi_rdata     = s_reg.rdata;
  assign s_axi_rresp     = s_reg.rresp;
  assign lcd_clk_source  = s_reg.clk_src;
  assign com_select      = s_reg.com_sel;
  assign com_pin_enable  = s_reg.com_pins;
  assign segment_line    = s_reg.seg_out;
  assign seg_pin_enable  = s_reg.seg_pins;
  assign drive_polarity  = s_reg.pol;
  assign bias_select     = s_reg.bias;
  assign charge_pump_on  = s_reg.pump;
  assign regulator_level = s_reg.level;
  assign regulator_third = s_reg.third;
  assign regulator_clock = s_reg.reg_clk;
  assign regulator_on    = s_reg.reg_on;
endmodule

//--- verification/lcd_drive_props.sv
// Concurrent checks on the ports of the segment LCD driver
module lcd_drive_props
  import lcd_drive_pkg::*;
(
  input wire logic        aclk,            // System clock
  input wire logic        aresetn,         // Synchronous reset, low
  input wire logic        s_axi_arready,   // Read address ready
  input wire logic [31:0] s_axi_rdata,     // Read data
  input wire logic        s_axi_rvalid,    // Read data valid
  input wire logic        s_axi_rready,    // Read data ready
  input wire logic [1:0]  s_axi_bresp,     // Write response
  input wire logic        s_axi_bvalid,    // Write response valid
  input wire logic        s_axi_bready,    // Write response ready
  input wire logic [7:0]  com_select,      // Active common
  input wire logic [7:0]  com_pin_enable,  // Commons in use
  input wire logic [63:0] segment_line,    // Segment levels
  input wire logic [63:0] seg_pin_enable,  // Segment pin ownership
  input wire logic [1:0]  bias_select,     // Bias mode
  input wire logic [2:0]  regulator_level, // Peak level code
  input wire logic        regulator_third, // Third-bias regulator
  input wire logic [1:0]  regulator_clock, // Regulator clock code
  input wire logic        regulator_on     // Regulator running
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  // Bus answers must wait for the master
  sequence s_rwait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  sequence s_bwait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  property p_rhold;
    s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_bhold;
    s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  // Regulator level and mode come out of reset at their ones values
  property p_rst_vals;
    $rose(aresetn) |-> regulator_level == CP_LEVEL_RESET
      && regulator_third == CP_THIRD_RESET;
  endproperty
  // Commons in use always form a run from common zero
  property p_com_run;
    com_pin_enable[0] && ((com_pin_enable + 8'h01) & com_pin_enable) == 8'h00;
  endproperty
  property p_static_bias;
    (com_pin_enable == 8'h01) == (bias_select == BIAS_STATIC);
  endproperty
  property p_third_bias;
    com_pin_enable[3] |-> bias_select == BIAS_THIRD;
  endproperty
  property p_shared;
    com_pin_enable[4] |-> seg_pin_enable[62:59] == 4'h0;
  endproperty
  property p_seg63;
    seg_pin_enable[63] == 1'b0;
  endproperty
  property p_reg_on;
    regulator_on == (regulator_clock != 2'h0);
  endproperty
  property p_com_used;
    com_select != 8'h00 |-> $onehot(com_select)
      && (com_select & ~com_pin_enable) == 8'h00;
  endproperty
  property p_seg_mask;
    (segment_line & ~seg_pin_enable) == 64'h0;
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  a_bhold: assert property (p_bhold) else $error("write response moved");
  a_ar_busy: assert property (p_ar_busy) else $error("read taken early");
  a_rst_vals: assert property (p_rst_vals)
    else $error("regulator reset value wrong");
  a_com_run: assert property (p_com_run)
    else $error("commons in use not contiguous");
  a_static_bias: assert property (p_static_bias)
    else $error("static bias mismatch");
  a_third_bias: assert property (p_third_bias)
    else $error("third bias expected");
  a_shared: assert property (p_shared)
    else $error("shared pins still segments");
  a_seg63: assert property (p_seg63)
    else $error("segment 63 enabled");
  a_reg_on: assert property (p_reg_on)
    else $error("regulator run state wrong");
  a_com_used: assert property (p_com_used)
    else $error("bad active common");
  a_seg_mask: assert property (p_seg_mask)
    else $error("segment driven on disabled pin");
endmodule

//--- verification/lcd_glass_model.sv
// Glass panel model: records commons scanned and ticks between steps
module lcd_glass_model (
  input wire logic       aclk,           // Bench clock
  input wire logic       clear,          // Restart the record
  input wire logic       lcd_clk_tick,   // LCD clock pulse
  input wire logic [7:0] com_select,     // Driven common
  input wire logic       drive_polarity, // Waveform phase
  output logic [7:0]     com_seen,       // Commons seen since clear
  output logic [5:0]     step_gap        // Ticks between last two steps
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] last;
  logic [5:0] cnt;
  // A step is any change of common or phase; the panel cannot tell which
  always @(posedge aclk)
  begin
    if (clear)
    begin
      com_seen <= 8'h00;
      cnt <= 6'h00;
      last <= {com_select, drive_polarity};
    end
    else if ({com_select, drive_polarity} != last)
    begin
      last <= {com_select, drive_polarity};
      step_gap <= cnt;
      cnt <= {5'h00, lcd_clk_tick};
      com_seen <= com_seen | com_select;
    end
    else if (lcd_clk_tick)
      cnt <= cnt + 6'h01;
  end
endmodule

//--- verification/testbench.sv
// Self-checking bench for the segment LCD driver
module testbench;
  import lcd_drive_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, lcd_clk_tick, clear;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, com_select, com_pin_enable;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, drive_polarity, charge_pump_on;
  logic        regulator_third, regulator_on;
  logic [1:0]  s_axi_bresp, s_axi_rresp, lcd_clk_source, bias_select, rs;
  logic [1:0]  regulator_clock;
  logic [2:0]  regulator_level;
  logic [63:0] segment_line, seg_pin_enable;
  logic [7:0]  com_seen;
  logic [5:0]  step_gap;
  logic [15:0] pix [32];
  logic [15:0] ena [4];
  logic [15:0] d;
  int          err_count, n_compared, cyc;
  segment_lcd_drive_control dut_u (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .lcd_clk_tick, .lcd_clk_source, .com_select,
    .com_pin_enable, .segment_line, .seg_pin_enable, .drive_polarity,
    .bias_select,
    .charge_pump_on, .regulator_level, .regulator_third, .regulator_clock,
    .regulator_on);
  lcd_glass_model glass_u (.aclk, .clear, .lcd_clk_tick, .com_select,
    .drive_polarity, .com_seen, .step_gap);
  ////////////////////////////////////////////////////////////////////////
  // Clock, random LCD ticks and a hang guard
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    lcd_clk_tick <= 1'($urandom);
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Bus cycles: requests held until taken, answer held until accepted
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdw(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] v);
    rdw(a);
    chk(rd, {16'h0000, v});
    chk(rs, RESP_OKAY);
  endtask
  // Expected pin ownership and segment levels
  function automatic logic [63:0] sexp(input logic [2:0] c);
    logic [63:0] e;
    e = {ena[3], ena[2], ena[1], ena[0]} & SEG_IMPL_MASK;
    if (c >= MUX_FIVE) e[SHARED_SEG_BASE +: 4] = 4'h0;
    return e;
  endfunction
  function automatic logic [63:0] lexp(input logic [2:0] c, input int k);
    return {pix[4*k+3], pix[4*k+2], pix[4*k+1], pix[4*k]} & sexp(c);
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // One commons code: run, compare scan, then drain to idle
  task automatic run_mux(input logic [2:0] c);
    logic [3:0]  pre;
    logic [15:0] ph;
    logic [7:0]  ce;
    int          k;
    pre = (c == 3'h7) ? 4'hF : 4'($urandom_range(3, 0));
    ph = {8'h00, 1'($urandom), 3'h0, pre};
    // Half bias only offered with two or three commons
    if (c == 3'h1 || c == 3'h2) ph[PH_BIAS_MODE_BIT] = 1'($urandom);
    ce = 8'((9'h002 << c) - 9'h001);
    wr(PHASE_CTRL_ADDR, ph);
    wr(MAIN_CTRL_ADDR, {13'h1000, c});
    clear <= 1'b1;
    @(posedge aclk);
    clear <= 1'b0;
    repeat ((c == 3'h7) ? 1200 : 400) @(posedge aclk);
    chk(com_pin_enable, ce);
    chk(bias_select, (c == 3'h0) ? BIAS_STATIC :
      (ph[PH_BIAS_MODE_BIT] ? BIAS_HALF : BIAS_THIRD));
    chk(seg_pin_enable, sexp(c));
    chk(com_seen, ce);
    chk(step_gap, pre + 5'h01);
    @(negedge aclk);
    k = 0;
    for (int j = 0; j < 8; j++) if (com_select[j]) k = j;
    chk(segment_line, lexp(c, k));
    rdw(PHASE_CTRL_ADDR);
    chk(rd[PH_ACTIVE_BIT], 1'b1);
    if (c == 3'h7)
    begin
      // Write a pixel early in the frame, far from the last common
      k = 0;
      do
      begin
        rdw(PHASE_CTRL_ADDR);
        k++;
      end
      while ((rd[PH_WR_ALLOW_BIT] !== 1'b0 || com_select[0] !== 1'b1)
        && k < 200);
      wr(PIXEL_BASE, ~pix[0]);
      rdc(MAIN_CTRL_ADDR, 16'h8027);
      rdc(PIXEL_BASE, pix[0]);
      wr(MAIN_CTRL_ADDR, 16'h8007);
      rdc(MAIN_CTRL_ADDR, 16'h8007);
    end
    // Disable keeps the commons code so the frame drains over used commons
    wr(MAIN_CTRL_ADDR, {13'h0000, c});
    k = 0;
    while (com_select !== 8'h00 && k < 3000)
    begin
      @(posedge aclk);
      k++;
    end
    rdc(PHASE_CTRL_ADDR, ph | 16'h0010);
  endtask
  // Main sequence
  initial
  begin
    {aresetn, lcd_clk_tick, clear, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h3;
    {err_count, n_compared, cyc} = '0;
    void'($urandom(51398));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdc(CPUMP_CTRL_ADDR, 16'h003C);
    rdc(MAIN_CTRL_ADDR, 16'h0000);
    rdc(PHASE_CTRL_ADDR, 16'h0010);
    rdw(8'h40);
    chk(rs, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h44, 16'hFFFF);
    chk(rs, RESP_SLVERR);
    for (int i = 0; i < 4; i++)
    begin
      d = 16'($urandom);
      d[1:0] = 2'(i);
      wr(CPUMP_CTRL_ADDR, d);
      chk({charge_pump_on, regulator_level, regulator_third, regulator_clock,
        regulator_on}, {d[15], d[5:0], i != 0});
      rdc(CPUMP_CTRL_ADDR, d & 16'h803F);
    end
    wr(PHASE_CTRL_ADDR, 16'hFFBF);
    rdc(PHASE_CTRL_ADDR, 16'h009F);
    for (int i = 0; i < 4; i++)
    begin
      ena[i] = 16'($urandom);
      wr(8'(SEG_EN_BASE + 4 * i), ena[i]);
      d = (i == 3) ? ena[i] & 16'h7FFF : ena[i];
      rdc(8'(SEG_EN_BASE + 4 * i), d);
    end
    chk(seg_pin_enable, sexp(3'h0));
    for (int i = 0; i < 32; i++)
    begin
      pix[i] = 16'($urandom);
      wr(8'(PIXEL_BASE + 4 * i), pix[i]);
      rdc(8'(PIXEL_BASE + 4 * i), pix[i]);
    end
    for (int c = 0; c < 8; c++) run_mux(3'(c));
    summarize();
  end
endmodule
bind segment_lcd_drive_control lcd_drive_props chk_u (.aclk, .aresetn,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .com_select, .com_pin_enable, .segment_line,
  .seg_pin_enable, .bias_select, .regulator_level, .regulator_third,
  .regulator_clock, .regulator_on);
